//--- pkg/conv_seq_pkg.sv
package conv_seq_pkg;

	// ****************************************
	// Register map, byte addresses
	// ****************************************
	localparam logic [7:0] CTRL_MAIN_ADDR   = 8'h00;
	localparam logic [7:0] CTRL_SECOND_ADDR = 8'h04;
	localparam logic [7:0] CTRL_THIRD_ADDR  = 8'h08;
	localparam logic [7:0] RESULT_ADDR      = 8'h0C;
	localparam logic [7:0] CLEAR_ADDR       = 8'h10;

	// ****************************************
	// Main control fields
	// ****************************************
	localparam int EN_BIT    = 0;
	localparam int START_BIT = 1;
	localparam int CONT_BIT  = 2;
	localparam int CHOP_BIT  = 3;
	localparam int MUTE_BIT  = 4;
	localparam int SIGN_BIT  = 5;
	localparam int FLAG_BIT  = 6;
	localparam int REGON_BIT = 7;
	localparam int COREON_BIT = 8;

	// ****************************************
	// Second control fields
	// ****************************************
	localparam int ATTN_LSB  = 0;
	localparam int SMPL_LSB  = 4;
	localparam int STORE_LSB = 8;
	localparam int AVG_LSB   = 16;

	// ****************************************
	// Third control fields
	// ****************************************
	localparam int ENDEL_LSB = 0;
	localparam int INTV_LSB  = 8;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [31:0] CTRL_MAIN_RST   = 32'h0000_0000;
	localparam logic [31:0] CTRL_SECOND_RST = 32'h0000_0100;
	localparam logic [31:0] CTRL_THIRD_RST  = 32'h0000_0040;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_KHZ       = 16000;
	localparam int ENDEL_UNIT    = 4;
	localparam int SMPL_UNIT     = 8;
	localparam int TICK_US       = 1024;
	localparam int TICK_CYCLES   = TICK_US * CLK_KHZ / 1000;

	typedef enum logic [1:0] {
		AXI_OKAY   = 2'b00,
		AXI_SLVERR = 2'b10
	} resp_type;

endpackage : conv_seq_pkg

//--- rtl/adc_conversion_sequencer.sv
// How it works
// - Enable starts regulator, core after delay
// - Enable delay counts four-cycle units
// - Start write begins conversion, reads busy
// - Completion sets done flag, clears start unless continuous
// - Start while busy is ignored
// - Continuous mode relaunches after each conversion
// - Pause equals interval times 1.024 ms
// - Nonzero interval syncs to slow tick
// - Sampling lasts eight cycles per unit
// - Store delay zero selects handshake
// - Fixed store after delay plus one
// - Handshake result via two sync cycles
// - Average two-power-exponent samples
// - Result kept 16-bit left aligned
// - Chopper sums two opposite-sign conversions
// - Chopping alternates sign, minimum two
// - Attenuation field drives input scaling
// - Mute ties input to midscale
// - Sign bit inverts offset polarity
// - All counts on 16 MHz clock
// - Interrupt and DMA from completion
// - Clear-register write clears flag unless completion sets it that cycle
`timescale 1ns/1ps

module adc_conversion_sequencer #(
	parameter int TICK_CYCLES = conv_seq_pkg::TICK_CYCLES
) (
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	input  wire logic [7:0]  s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [7:0]  s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	output logic             regulator_en_o,
	output logic             core_en_o,
	output logic             sample_o,
	output logic             convert_o,
	output logic             offset_sign_o,
	output logic [1:0]       attenuation_o,
	output logic             midscale_tie_o,
	input  wire logic        core_done_i,
	input  wire logic [9:0]  core_data_i,
	output logic             irq_o,
	output logic             dma_req_o
);

	if (TICK_CYCLES < 2 || TICK_CYCLES > 65535) begin : gen_tick_check
		$error("TICK_CYCLES out of range");
	end

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WAIT_TICK,
		ST_PAUSE,
		ST_SAMPLE,
		ST_CONVERT,
		ST_STORE
	} phase_type;

	typedef struct packed {
		logic        aw_got;
		logic        w_got;
		logic [7:0]  aw_addr;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [31:0] ctrl_main;
		logic [31:0] ctrl_second;
		logic [31:0] ctrl_third;
		logic        busy;
		logic        flag;
		logic        dma;
		logic        reg_on;
		logic        core_on;
		logic [9:0]  en_cnt;
		logic [1:0]  en_sub;
		logic [15:0] tick_cnt;
		logic        tick;
		logic [7:0]  intv_cnt;
		phase_type   phase;
		logic [10:0] ph_cnt;
		logic [7:0]  conv_left;
		logic        sign_alt;
		logic        sync1;
		logic        sync2;
		logic [9:0]  last_sample;
		logic [17:0] acc;
		logic [15:0] result;
		logic        started_once;
	} state_type;

	state_type s_r;
	state_type s_nxt;

	logic        wr_fire;
	logic [7:0]  smpl_time;
	logic [7:0]  store_del;
	logic [2:0]  avg_exp;
	logic [7:0]  intv;
	logic [7:0]  en_del;
	logic [7:0]  n_conv;
	logic [17:0] sum;
	logic [31:0] wmask;

	assign smpl_time = s_r.ctrl_second[conv_seq_pkg::SMPL_LSB +: 4] == 4'h0 ? 8'h01
	                 : {4'h0, s_r.ctrl_second[conv_seq_pkg::SMPL_LSB +: 4]};
	assign store_del = s_r.ctrl_second[conv_seq_pkg::STORE_LSB +: 8];
	assign avg_exp   = s_r.ctrl_second[conv_seq_pkg::AVG_LSB +: 3];
	assign intv      = s_r.ctrl_third[conv_seq_pkg::INTV_LSB +: 8];
	assign en_del    = s_r.ctrl_third[conv_seq_pkg::ENDEL_LSB +: 8];
	assign n_conv    = (s_r.ctrl_main[conv_seq_pkg::CHOP_BIT] && avg_exp == 3'h0) ? 8'h02
	                 : 8'((9'h001) << avg_exp);
	assign wr_fire   = s_r.aw_got && s_r.w_got && !s_r.bvalid;
	assign wmask     = {{8{s_r.w_strb[3]}}, {8{s_r.w_strb[2]}}, {8{s_r.w_strb[1]}}, {8{s_r.w_strb[0]}}};

	always_comb begin
		s_nxt = s_r;
		sum   = 18'h0_0000;
		s_nxt.tick = 1'b0;

		// ****************************************
		// AXI4-Lite slave
		// ****************************************
		if (s_axi_awvalid_i && !s_r.aw_got) begin
			s_nxt.aw_got  = 1'b1;
			s_nxt.aw_addr = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && !s_r.w_got) begin
			s_nxt.w_got  = 1'b1;
			s_nxt.w_data = s_axi_wdata_i;
			s_nxt.w_strb = s_axi_wstrb_i;
		end
		if (s_r.bvalid && s_axi_bready_i) begin
			s_nxt.bvalid = 1'b0;
		end
		if (s_r.rvalid && s_axi_rready_i) begin
			s_nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid_i && !s_r.rvalid) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp  = conv_seq_pkg::AXI_OKAY;
			unique case (s_axi_araddr_i)
				conv_seq_pkg::CTRL_MAIN_ADDR: begin
					s_nxt.rdata = s_r.ctrl_main;
					s_nxt.rdata[conv_seq_pkg::START_BIT]  = s_r.busy;
					s_nxt.rdata[conv_seq_pkg::FLAG_BIT]   = s_r.flag;
					s_nxt.rdata[conv_seq_pkg::REGON_BIT]  = s_r.reg_on;
					s_nxt.rdata[conv_seq_pkg::COREON_BIT] = s_r.core_on;
				end
				conv_seq_pkg::CTRL_SECOND_ADDR: s_nxt.rdata = s_r.ctrl_second;
				conv_seq_pkg::CTRL_THIRD_ADDR:  s_nxt.rdata = s_r.ctrl_third;
				conv_seq_pkg::RESULT_ADDR:      s_nxt.rdata = {16'h0000, s_r.result};
				conv_seq_pkg::CLEAR_ADDR:       s_nxt.rdata = 32'h0000_0000;
				default: begin
					s_nxt.rdata = 32'h0000_0000;
					s_nxt.rresp = conv_seq_pkg::AXI_SLVERR;
				end
			endcase
		end

		// ****************************************
		// Slow delay clock
		// ****************************************
		if (s_r.tick_cnt == 16'(TICK_CYCLES - 1)) begin
			s_nxt.tick_cnt = 16'h0000;
			s_nxt.tick     = 1'b1;
		end else begin
			s_nxt.tick_cnt = s_r.tick_cnt + 16'h0001;
		end

		// ****************************************
		// Enable sequence
		// ****************************************
		// regulator then core
		if (!s_r.ctrl_main[conv_seq_pkg::EN_BIT]) begin
			s_nxt.reg_on  = 1'b0;
			s_nxt.core_on = 1'b0;
			s_nxt.en_cnt  = 10'h000;
			s_nxt.en_sub  = 2'h0;
		end else begin
			s_nxt.reg_on = 1'b1;
			if (s_r.reg_on && !s_r.core_on) begin
				s_nxt.en_sub = s_r.en_sub + 2'h1;
				if (s_r.en_sub == 2'(conv_seq_pkg::ENDEL_UNIT - 1)) begin
					s_nxt.en_cnt = s_r.en_cnt + 10'h001;
				end
				if (s_r.en_cnt >= {2'h0, en_del}) begin
					s_nxt.core_on = 1'b1;
				end
			end
		end

		// ****************************************
		// Conversion sequencer
		// ****************************************
		s_nxt.sync1 = core_done_i;
		s_nxt.sync2 = s_r.sync1;
		unique case (s_r.phase)
			ST_IDLE: begin
				if (s_r.busy && s_r.core_on) begin
					s_nxt.phase     = ST_SAMPLE;
					s_nxt.ph_cnt    = 11'h000;
					s_nxt.conv_left = n_conv;
					s_nxt.acc       = 18'h0_0000;
					s_nxt.sign_alt  = 1'b0;
				end
			end
			ST_WAIT_TICK: begin
				if (s_r.tick) begin
					s_nxt.phase    = ST_PAUSE;
					s_nxt.intv_cnt = intv;
				end
			end
			ST_PAUSE: begin
				if (s_r.tick) begin
					s_nxt.intv_cnt = s_r.intv_cnt - 8'h01;
					if (s_r.intv_cnt == 8'h01) begin
						s_nxt.phase     = ST_SAMPLE;
						s_nxt.ph_cnt    = 11'h000;
						s_nxt.conv_left = n_conv;
						s_nxt.acc       = 18'h0_0000;
						s_nxt.sign_alt  = 1'b0;
					end
				end
			end
			ST_SAMPLE: begin
				s_nxt.ph_cnt = s_r.ph_cnt + 11'h001;
				if (s_r.ph_cnt == 11'(smpl_time * conv_seq_pkg::SMPL_UNIT - 1)) begin
					s_nxt.phase  = ST_CONVERT;
					s_nxt.ph_cnt = 11'h000;
				end
			end
			ST_CONVERT: begin
				s_nxt.ph_cnt = s_r.ph_cnt + 11'h001;
				if (store_del == 8'h00) begin
					if (s_r.sync2) begin
						s_nxt.last_sample = core_data_i;
						s_nxt.phase       = ST_STORE;
					end
				end else if (s_r.ph_cnt == {3'h0, store_del}) begin
					if (s_r.sync2) begin
						s_nxt.last_sample = core_data_i;
					end
					s_nxt.phase = ST_STORE;
				end
			end
			ST_STORE: begin
				sum = s_r.acc + {8'h00, s_r.last_sample};
				s_nxt.acc       = sum;
				s_nxt.conv_left = s_r.conv_left - 8'h01;
				s_nxt.sign_alt  = ~s_r.sign_alt;
				if (s_r.conv_left != 8'h01) begin
					s_nxt.phase  = ST_SAMPLE;
					s_nxt.ph_cnt = 11'h000;
				end else begin
					s_nxt.result = 16'(({6'h00, sum} << 6)
					               >> (n_conv == 8'h01 ? 3'h0 : avg_exp == 3'h0 ? 3'h1 : avg_exp));
					s_nxt.dma    = 1'b1;
					s_nxt.flag   = 1'b1;
					if (s_r.ctrl_main[conv_seq_pkg::CONT_BIT] && s_r.core_on) begin
						if (intv == 8'h00) begin
							s_nxt.phase     = ST_SAMPLE;
							s_nxt.ph_cnt    = 11'h000;
							s_nxt.conv_left = n_conv;
							s_nxt.acc       = 18'h0_0000;
							s_nxt.sign_alt  = 1'b0;
						end else begin
							s_nxt.phase = ST_WAIT_TICK;
						end
					end else begin
						s_nxt.phase = ST_IDLE;
						s_nxt.busy  = 1'b0;
					end
				end
			end
		endcase
		if (!s_r.ctrl_main[conv_seq_pkg::EN_BIT]) begin
			s_nxt.phase = ST_IDLE;
			s_nxt.busy  = 1'b0;
		end

		if (s_r.dma) begin
			s_nxt.dma = 1'b0;
		end

		// ****************************************
		// Register writes
		// ****************************************
		if (wr_fire) begin
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got  = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp  = conv_seq_pkg::AXI_OKAY;
			unique case (s_r.aw_addr)
				conv_seq_pkg::CTRL_MAIN_ADDR: begin
					s_nxt.ctrl_main = (s_r.ctrl_main & ~wmask) | (s_r.w_data & wmask & 32'h0000_003D);
					if (s_r.w_strb[0] && s_r.w_data[conv_seq_pkg::START_BIT] && !s_r.busy
					    && s_r.w_data[conv_seq_pkg::EN_BIT]) begin
						s_nxt.busy = 1'b1;
					end
				end
				conv_seq_pkg::CTRL_SECOND_ADDR: s_nxt.ctrl_second = (s_r.ctrl_second & ~wmask) | (s_r.w_data & wmask);
				conv_seq_pkg::CTRL_THIRD_ADDR:  s_nxt.ctrl_third  = (s_r.ctrl_third & ~wmask) | (s_r.w_data & wmask);
				conv_seq_pkg::RESULT_ADDR: begin
				end
				conv_seq_pkg::CLEAR_ADDR: begin
					if (!(s_r.phase == ST_STORE && s_r.conv_left == 8'h01)) begin
						s_nxt.flag = 1'b0;
					end
				end
				default: s_nxt.bresp = conv_seq_pkg::AXI_SLVERR;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_r             <= '0;
			s_r.phase       <= ST_IDLE;
			s_r.ctrl_main   <= conv_seq_pkg::CTRL_MAIN_RST;
			s_r.ctrl_second <= conv_seq_pkg::CTRL_SECOND_RST;
			s_r.ctrl_third  <= conv_seq_pkg::CTRL_THIRD_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign s_axi_awready_o = !s_r.aw_got;
	assign s_axi_wready_o  = !s_r.w_got;
	assign s_axi_bvalid_o  = s_r.bvalid;
	assign s_axi_bresp_o   = s_r.bresp;
	assign s_axi_arready_o = !s_r.rvalid;
	assign s_axi_rvalid_o  = s_r.rvalid;
	assign s_axi_rdata_o   = s_r.rdata;
	assign s_axi_rresp_o   = s_r.rresp;
	assign regulator_en_o  = s_r.reg_on;
	assign core_en_o       = s_r.core_on;
	assign sample_o        = s_r.phase == ST_SAMPLE;
	assign convert_o       = s_r.phase == ST_CONVERT;
	assign offset_sign_o   = s_r.ctrl_main[conv_seq_pkg::SIGN_BIT]
	                       ^ (s_r.ctrl_main[conv_seq_pkg::CHOP_BIT] & s_r.sign_alt);
	assign attenuation_o   = s_r.ctrl_second[conv_seq_pkg::ATTN_LSB +: 2];
	assign midscale_tie_o  = s_r.ctrl_main[conv_seq_pkg::MUTE_BIT];
	assign irq_o           = s_r.flag;
	assign dma_req_o       = s_r.dma;

endmodule : adc_conversion_sequencer

//--- tb/adc_conversion_sequencer_checker.sv
`timescale 1ns/1ps
module adc_conversion_sequencer_checker #(
	parameter int TICK_CYCLES = 8
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic regulator_en_o,
	input wire logic core_en_o,
	input wire logic sample_o,
	input wire logic convert_o,
	input wire logic offset_sign_o,
	input wire logic midscale_tie_o,
	input wire logic irq_o,
	input wire logic dma_req_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	// ********
	// Assertions and covers
	// ********
	a_core_needs_reg: assert property (core_en_o |-> regulator_en_o)
		else $error("core enabled without regulator");
	a_reg_lead_time: assert property ($rose(core_en_o) |-> $past(regulator_en_o, 4))
		else $error("core enabled too soon");
	a_sample_gated: assert property (sample_o |-> core_en_o)
		else $error("sampling before core enable");
	a_sample_length: assert property ($rose(sample_o) |-> sample_o[*8])
		else $error("sampling shorter than eight cycles");
	a_sample_to_conv: assert property ($fell(sample_o) && core_en_o |-> convert_o)
		else $error("conversion did not follow sampling");
	a_phase_exclusive: assert property (!(sample_o && convert_o))
		else $error("sampling and conversion overlap");
	a_dma_pulse: assert property (dma_req_o |=> !dma_req_o)
		else $error("dma request longer than one cycle");
	a_irq_follows: assert property (dma_req_o |-> ##[0:1] irq_o)
		else $error("done flag missing at completion");
	a_sign_steady: assert property (sample_o && $past(sample_o) |-> $stable(offset_sign_o))
		else $error("offset sign moved during sampling");
	c_chop: cover property ($fell(offset_sign_o) && midscale_tie_o);
	c_done: cover property (dma_req_o);
	c_core: cover property ($rose(core_en_o));
endmodule : adc_conversion_sequencer_checker

bind adc_conversion_sequencer adc_conversion_sequencer_checker #(.TICK_CYCLES(TICK_CYCLES)) chk (
	.clk_i, .rstn_i, .regulator_en_o, .core_en_o, .sample_o, .convert_o, .offset_sign_o, .midscale_tie_o,
	.irq_o, .dma_req_o);

//--- tb/adc_conversion_sequencer_tb_top.sv
`timescale 1ns/1ps
module adc_conversion_sequencer_tb_top;
	localparam int TICKS = 8;
	logic        clk_i, rstn_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
	logic        s_axi_arvalid_i, s_axi_rready_i, s_axi_awready_o, s_axi_wready_o;
	logic        s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, regulator_en_o, core_en_o;
	logic        sample_o, convert_o, offset_sign_o, midscale_tie_o, core_done_i, irq_o, dma_req_o;
	logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i;
	logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
	logic [3:0]  s_axi_wstrb_i;
	logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, attenuation_o, bresp_seen;
	logic [9:0]  core_data_i, level;
	logic [4:0]  latency;
	int          miscompares, checks_done, dma_cnt;
	realtime     t_core;

	adc_conversion_sequencer #(.TICK_CYCLES(TICKS)) DUT (.clk_i, .rstn_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
		.s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
		.s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
		.s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .regulator_en_o, .core_en_o, .sample_o, .convert_o,
		.offset_sign_o, .attenuation_o, .midscale_tie_o, .core_done_i, .core_data_i, .irq_o, .dma_req_o);
	conv_core_model core (.clk_i, .core_en_i(core_en_o), .convert_i(convert_o), .offset_sign_i(offset_sign_o),
		.midscale_tie_i(midscale_tie_o), .latency_i(latency), .level_i(level), .core_done_o(core_done_i),
		.core_data_o(core_data_i));

	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) if (dma_req_o === 1'b1) dma_cnt++;
	always @(posedge core_en_o) t_core = $realtime;

	// ********
	// Bus and compare tasks
	// ********
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic chk_bit(input string what, input logic exp, input logic got);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %b seen %b", what, exp, got);
		end
	endtask : chk_bit
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		s_axi_awaddr_i  <= a;
		s_axi_wdata_i   <= d;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i  <= 1'b1;
		s_axi_bready_i  <= 1'b1;
		forever begin
			@(posedge clk_i);
			if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
			if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
			if (s_axi_bvalid_o) begin
				bresp_seen = s_axi_bresp_o;
				break;
			end
		end
		s_axi_bready_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_i);
		s_axi_araddr_i  <= a;
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i  <= 1'b1;
		forever begin
			@(posedge clk_i);
			if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
			d = s_axi_rdata_o;
			r = s_axi_rresp_o;
			if (s_axi_rvalid_o) break;
		end
		s_axi_rready_i <= 1'b0;
	endtask : rd
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk(what, exp, d);
	endtask : rdchk
	task automatic wait_idle();
		logic [31:0] d;
		logic [1:0]  r;
		forever begin
			rd(conv_seq_pkg::CTRL_MAIN_ADDR, d, r);
			if (d[conv_seq_pkg::START_BIT] === 1'b0) break;
		end
	endtask : wait_idle
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : end_sim

	// ********
	// Scenarios
	// ********
	task automatic t_reset();
		logic [31:0] d;
		logic [1:0]  r;
		rdchk(conv_seq_pkg::CTRL_MAIN_ADDR, conv_seq_pkg::CTRL_MAIN_RST, "main reset");
		rdchk(conv_seq_pkg::CTRL_SECOND_ADDR, conv_seq_pkg::CTRL_SECOND_RST, "second reset");
		rdchk(conv_seq_pkg::CTRL_THIRD_ADDR, conv_seq_pkg::CTRL_THIRD_RST, "third reset");
		rd(8'h14, d, r);
		chk_bit("unmapped read", 1'b1, r === conv_seq_pkg::AXI_SLVERR);
		wr(8'h14, 32'h0000_0000);
		chk("unmapped write", conv_seq_pkg::AXI_SLVERR, bresp_seen);
		$display("reset test done");
	endtask : t_reset
	task automatic t_single();
		logic [31:0] d;
		logic [1:0]  r;
		realtime     t_en;
		wr(conv_seq_pkg::CTRL_SECOND_ADDR, 32'h0000_0010);
		wr(conv_seq_pkg::CTRL_THIRD_ADDR, 32'h0000_0002);
		chk("write response", conv_seq_pkg::AXI_OKAY, bresp_seen);
		wr(conv_seq_pkg::CTRL_MAIN_ADDR, 32'h0000_0003);
		t_en = $realtime;
		// The regulator follows the enable bit one edge after the write lands.
		@(posedge clk_i);
		chk_bit("regulator on", 1'b1, regulator_en_o);
		chk_bit("core held off", 1'b0, core_en_o);
		rd(conv_seq_pkg::CTRL_MAIN_ADDR, d, r);
		chk_bit("busy before core", 1'b1, d[conv_seq_pkg::START_BIT]);
		wr(conv_seq_pkg::CTRL_MAIN_ADDR, 32'h0000_0003);
		wait_idle();
		chk_bit("enable delay", 1'b1, (t_core - t_en) >= 30.0 && (t_core - t_en) <= 80.0);
		chk("one result", 32'h0000_0001, dma_cnt);
		chk_bit("flag set", 1'b1, irq_o);
		rdchk(conv_seq_pkg::RESULT_ADDR, 32'h0000_A940, "result");
		wr(conv_seq_pkg::CLEAR_ADDR, 32'h0000_5A5A);
		chk_bit("flag cleared", 1'b0, irq_o);
		$display("single test done");
	endtask : t_single
	task automatic t_fixed();
		level   <= 10'h155;
		latency <= 5'h14;
		wr(conv_seq_pkg::CTRL_SECOND_ADDR, 32'h0000_0310);
		wr(conv_seq_pkg::CTRL_MAIN_ADDR, 32'h0000_0003);
		wait_idle();
		rdchk(conv_seq_pkg::RESULT_ADDR, 32'h0000_A940, "stale result");
		latency <= 5'h0;
		level   <= 10'h2A5;
		$display("fixed delay test done");
	endtask : t_fixed
	task automatic t_modes();
		logic [31:0] ctl [4] = '{32'h0000_001B, 32'h0000_001B, 32'h0000_0013, 32'h0000_0033};
		logic [31:0] avg [4] = '{32'h0000_0010, 32'h0002_0011, 32'h0003_0012, 32'h0001_0013};
		logic [31:0] res [4] = '{32'h0000_8000, 32'h0000_8000, 32'h0000_80C0, 32'h0000_7F40};
		int c;
		c = dma_cnt;
		for (int i = 0; i < 4; i++) begin
			wr(conv_seq_pkg::CTRL_SECOND_ADDR, avg[i]);
			chk("attenuation", i, {30'h0, attenuation_o});
			wr(conv_seq_pkg::CTRL_MAIN_ADDR, ctl[i]);
			chk_bit("midscale tie", 1'b1, midscale_tie_o);
			wait_idle();
			rdchk(conv_seq_pkg::RESULT_ADDR, res[i], "mode result");
			chk("results per run", c + i + 1, dma_cnt);
		end
		$display("mode test done");
	endtask : t_modes
	task automatic t_cont();
		int lo [2] = '{8, TICKS + 12};
		int hi [2] = '{22, 2 * TICKS + 40};
		int n;
		int c;
		wr(conv_seq_pkg::CTRL_SECOND_ADDR, 32'h0000_0010);
		for (int k = 0; k < 2; k++) begin
			wr(conv_seq_pkg::CTRL_THIRD_ADDR, {16'h0, 8'(k), 8'h02});
			wr(conv_seq_pkg::CTRL_MAIN_ADDR, 32'h0000_0007);
			for (n = 0; n < 300 && dma_req_o !== 1'b1; n++) @(posedge clk_i);
			@(posedge clk_i);
			for (n = 1; n < 300 && dma_req_o !== 1'b1; n++) @(posedge clk_i);
			chk_bit("repeat gap", 1'b1, n >= lo[k] && n <= hi[k]);
			wr(conv_seq_pkg::CTRL_MAIN_ADDR, 32'h0000_0001);
			wait_idle();
			c = dma_cnt;
			repeat (100) @(posedge clk_i);
			chk("stopped", c, dma_cnt);
			rdchk(conv_seq_pkg::RESULT_ADDR, 32'h0000_A940, "latest result");
		end
		$display("continuous test done");
	endtask : t_cont

	initial begin
		{s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = 5'h00;
		s_axi_awaddr_i = 8'h00;
		s_axi_araddr_i = 8'h00;
		s_axi_wdata_i  = 32'h0000_0000;
		s_axi_wstrb_i  = 4'hF;
		level          = 10'h2A5;
		latency        = 5'h0;
		rstn_i         = 1'b0;
		repeat (10) @(posedge clk_i);
		rstn_i <= 1'b1;
		t_reset();
		t_single();
		t_fixed();
		t_modes();
		t_cont();
		end_sim();
	end
	// The tests need well under ten thousand cycles; four times that means a hang.
	initial begin
		#200000;
		miscompares++;
		end_sim();
	end
endmodule : adc_conversion_sequencer_tb_top

//--- tb/conv_core_model.sv
`timescale 1ns/1ps
module conv_core_model (
	input  wire logic       clk_i,
	input  wire logic       core_en_i,
	input  wire logic       convert_i,
	input  wire logic       offset_sign_i,
	input  wire logic       midscale_tie_i,
	input  wire logic [4:0] latency_i,
	input  wire logic [9:0] level_i,
	output logic            core_done_o,
	output logic [9:0]      core_data_o
);
	// ********
	// Analog core stand-in
	// ********
	logic [4:0] cnt_r;
	logic [9:0] val;
	assign val = midscale_tie_i ? (offset_sign_i ? 10'h1FD : 10'h203) : level_i;
	// Data is inverted while not done, so a stale read can never look valid.
	assign core_data_o = core_done_o ? val : ~val;
	always_ff @(posedge clk_i) begin
		if (!core_en_i || !convert_i) begin
			cnt_r       <= 5'h0;
			core_done_o <= 1'b0;
		end else if (cnt_r == latency_i) begin
			core_done_o <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 5'h1;
		end
	end
endmodule : conv_core_model
